// File: verilog/ebh_bus_ctrl.sv
// Sequencer for external bus strobes, wait states, hold and clock output.
// Assumes a core that pulses REQ_VALID only while BUS_IDLE is high, and
// pins READY, HOLD_N and OFF_N that are asynchronous to MCLK.
`default_nettype none

module ebh_bus_ctrl #(
  parameter int WS_W = ebh_pkg::WS_WIDTH
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [1:0] REQ_SPACE,
  input wire logic REQ_FETCH,
  input wire logic [WS_W-1:0] WAIT_STATES,
  input wire logic DIV_WR,
  input wire logic [1:0] DIV_SEL,
  input wire logic READY,
  input wire logic HOLD_N,
  input wire logic OFF_N,
  output logic BUS_IDLE,
  output logic ACC_DONE,
  output logic BUS_DRIVE_EN,
  output logic RW_O,
  output logic RW_OE,
  output logic IO_STROBE_N_O,
  output logic IO_STROBE_N_OE,
  output logic MEMORY_STROBE_N_O,
  output logic MEMORY_STROBE_N_OE,
  output logic DATA_SPACE_SEL_N_O,
  output logic PROGRAM_SPACE_SEL_N_O,
  output logic IO_SPACE_SEL_N_O,
  output logic SPACE_SEL_N_OE,
  output logic HOLD_ACK_N_O,
  output logic HOLD_ACK_N_OE,
  output logic WAIT_COMPLETE_N_O,
  output logic WAIT_COMPLETE_N_OE,
  output logic FETCH_INDICATOR_N_O,
  output logic FETCH_INDICATOR_N_OE,
  output logic DIVIDED_CLOCK_OUT_O,
  output logic DIVIDED_CLOCK_OUT_OE
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check: the count must reach the ready threshold
  if (WS_W < 2)
  begin : g_chk
    $error("WS_W too narrow for the ready threshold");
  end

  // Ready takes part only with enough software wait states
  function automatic logic ready_used(input logic [WS_W-1:0] ws);
    ready_used = (ws >= WS_W'(ebh_pkg::READY_MIN_WS));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  ebh_sync_if sync ();

  ebh_pin_sync u_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .pins({OFF_N, HOLD_N, READY}),
    .sync(sync.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  ebh_pkg::ebh_state_e state_q;
  ebh_pkg::ebh_state_e state_d;
  logic [WS_W-1:0] ws_q;
  logic [WS_W-1:0] ws_d;
  logic [WS_W-1:0] ws_left_q;
  logic [WS_W-1:0] ws_left_d;
  logic write_q;
  logic write_d;
  logic [1:0] space_q;
  logic [1:0] space_d;
  logic fetch_q;
  logic fetch_d;
  logic [1:0] div_sel_q;
  logic [1:0] div_cnt_q;
  logic [1:0] div_cnt_d;
  logic clk_out_d;

  wire logic accept = (state_q == ebh_pkg::ST_IDLE) && sync.hold_n && REQ_VALID;
  wire logic grant = (state_q == ebh_pkg::ST_IDLE) && !sync.hold_n;
  wire logic last_wait = (state_q == ebh_pkg::ST_SWWAIT) && (ws_left_q == WS_W'(1));
  wire logic wait_more = ready_used(ws_q) && !sync.ready;

  // Next state; hold waits for the idle slot so no access is cut
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ebh_pkg::ST_IDLE:
      begin
        if (grant)
          state_d = ebh_pkg::ST_HOLD; // R19 R8
        else if (accept)
          state_d = ebh_pkg::ST_ACCESS;
      end
      ebh_pkg::ST_ACCESS:
      begin
        if (ws_q == '0)
          state_d = ebh_pkg::ST_IDLE;
        else
          state_d = ebh_pkg::ST_SWWAIT;
      end
      ebh_pkg::ST_SWWAIT:
      begin
        if (last_wait)
          state_d = wait_more ? ebh_pkg::ST_XWAIT : ebh_pkg::ST_IDLE; // R2 R3
      end
      ebh_pkg::ST_XWAIT:
      begin
        if (sync.ready)
          state_d = ebh_pkg::ST_IDLE; // R1 R12
      end
      ebh_pkg::ST_HOLD:
      begin
        if (sync.hold_n)
          state_d = ebh_pkg::ST_IDLE;
      end
    endcase
  end

  // Attributes of the access, latched when it is taken
  assign ws_d = accept ? WAIT_STATES : ws_q;
  assign write_d = accept ? REQ_WRITE : write_q;
  assign space_d = accept ? REQ_SPACE : space_q;
  assign fetch_d = accept ? REQ_FETCH : fetch_q;
  assign ws_left_d = (state_q == ebh_pkg::ST_ACCESS) ? ws_q :
                     (state_q == ebh_pkg::ST_SWWAIT) ? ws_left_q - WS_W'(1) : ws_left_q;

  // Sequencer registers
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_q <= ebh_pkg::ST_IDLE;
      ws_q <= '0;
      ws_left_q <= '0;
      write_q <= 1'b0;
      space_q <= 2'h0;
      fetch_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ws_q <= ws_d;
      ws_left_q <= ws_left_d;
      write_q <= write_d;
      space_q <= space_d;
      fetch_q <= fetch_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin values, taken from the next state so each pin flop lines up with it
  wire logic act_d = (state_d == ebh_pkg::ST_ACCESS) || (state_d == ebh_pkg::ST_SWWAIT) ||
                     (state_d == ebh_pkg::ST_XWAIT);
  wire logic hold_d = (state_d == ebh_pkg::ST_HOLD);
  wire logic drive_d = !hold_d && sync.off_n;
  wire logic io_d = (space_d == 2'(ebh_pkg::SPACE_IO));
  wire logic rw_d = !(act_d && write_d); // R4
  wire logic io_strb_d = !(act_d && io_d); // R6
  wire logic mem_strb_d = !(act_d && !io_d && (space_d != 2'h3)); // R17
  wire logic ds_d = !(act_d && space_d == 2'(ebh_pkg::SPACE_DATA)); // R18
  wire logic ps_d = !(act_d && space_d == 2'(ebh_pkg::SPACE_PROG)); // R18
  wire logic is_d = !(act_d && io_d); // R18
  wire logic fetch_n_d = !(act_d && fetch_d && space_d == 2'(ebh_pkg::SPACE_PROG)); // R14
  // Low from the first software wait up to, not into, the last one
  wire logic wc_d = !((state_d == ebh_pkg::ST_SWWAIT) && ready_used(ws_d) &&
                      (ws_left_d > WS_W'(1))); // R11

  // Bus pins; every enable drops during hold and while float is low
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      RW_O <= 1'b1;
      IO_STROBE_N_O <= 1'b1;
      MEMORY_STROBE_N_O <= 1'b1;
      DATA_SPACE_SEL_N_O <= 1'b1;
      PROGRAM_SPACE_SEL_N_O <= 1'b1;
      IO_SPACE_SEL_N_O <= 1'b1;
      FETCH_INDICATOR_N_O <= 1'b1;
      WAIT_COMPLETE_N_O <= 1'b1;
      RW_OE <= 1'b1;
      IO_STROBE_N_OE <= 1'b1;
      MEMORY_STROBE_N_OE <= 1'b1;
      SPACE_SEL_N_OE <= 1'b1;
      BUS_DRIVE_EN <= 1'b1;
    end
    else
    begin
      RW_O <= rw_d;
      IO_STROBE_N_O <= io_strb_d;
      MEMORY_STROBE_N_O <= mem_strb_d;
      DATA_SPACE_SEL_N_O <= ds_d;
      PROGRAM_SPACE_SEL_N_O <= ps_d;
      IO_SPACE_SEL_N_O <= is_d;
      FETCH_INDICATOR_N_O <= fetch_n_d;
      WAIT_COMPLETE_N_O <= wc_d;
      RW_OE <= drive_d; // R5
      IO_STROBE_N_OE <= drive_d; // R7
      MEMORY_STROBE_N_OE <= drive_d; // R17
      SPACE_SEL_N_OE <= drive_d; // R18
      BUS_DRIVE_EN <= drive_d; // R8
    end
  end

  // Handshake and always-on pins; hold ack is driven high during reset
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      HOLD_ACK_N_O <= 1'b1; // R10
      HOLD_ACK_N_OE <= 1'b1; // R10
      WAIT_COMPLETE_N_OE <= 1'b1;
      FETCH_INDICATOR_N_OE <= 1'b1;
      DIVIDED_CLOCK_OUT_OE <= 1'b1;
      BUS_IDLE <= 1'b0;
      ACC_DONE <= 1'b0;
    end
    else
    begin
      HOLD_ACK_N_O <= !hold_d; // R9
      HOLD_ACK_N_OE <= sync.off_n; // R9
      WAIT_COMPLETE_N_OE <= sync.off_n; // R13
      FETCH_INDICATOR_N_OE <= sync.off_n; // R14
      DIVIDED_CLOCK_OUT_OE <= sync.off_n;
      BUS_IDLE <= (state_d == ebh_pkg::ST_IDLE) && sync.hold_n;
      ACC_DONE <= act_d == 1'b0 && state_q != ebh_pkg::ST_IDLE &&
                  state_q != ebh_pkg::ST_HOLD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock divider; a flop output cannot copy MCLK, so each level lasts
  // N cycles and the period is 2N cycles of MCLK
  assign div_cnt_d = (div_cnt_q >= div_sel_q) ? 2'h0 : div_cnt_q + 2'h1;
  assign clk_out_d = (div_cnt_q >= div_sel_q) ? !DIVIDED_CLOCK_OUT_O : DIVIDED_CLOCK_OUT_O;

  // Divider select and counter
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      div_sel_q <= ebh_pkg::DIV_SEL_RESET; // R16
      div_cnt_q <= 2'h0;
      DIVIDED_CLOCK_OUT_O <= 1'b0;
    end
    else
    begin
      if (DIV_WR)
        div_sel_q <= DIV_SEL; // R15
      div_cnt_q <= div_cnt_d;
      DIVIDED_CLOCK_OUT_O <= clk_out_d; // R15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the sequencer and pins
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_long_access;
    (state_q == ebh_pkg::ST_ACCESS) && ready_used(ws_q);
  endsequence

  sequence s_first_wait;
    (state_q == ebh_pkg::ST_SWWAIT) && !WAIT_COMPLETE_N_O;
  endsequence

  property p_ready_extend;
    (state_q == ebh_pkg::ST_XWAIT) && !sync.ready |=> state_q == ebh_pkg::ST_XWAIT;
  endproperty
  a_ready_extend: assert property (p_ready_extend) // R1
    else $error("ready low did not extend the access");

  property p_ready_ignored;
    last_wait && !ready_used(ws_q) |=> state_q == ebh_pkg::ST_IDLE;
  endproperty
  a_ready_ignored: assert property (p_ready_ignored) // R2
    else $error("ready examined with too few wait states");

  property p_ready_late;
    (state_q == ebh_pkg::ST_ACCESS) && ws_q != '0 |=> state_q == ebh_pkg::ST_SWWAIT;
  endproperty
  a_ready_late: assert property (p_ready_late) // R3
    else $error("ready stage entered before wait states ended");

  property p_rw_write;
    !RW_O |-> write_q && state_q != ebh_pkg::ST_IDLE && state_q != ebh_pkg::ST_HOLD;
  endproperty
  a_rw_write: assert property (p_rw_write) // R4
    else $error("direction low outside a write");

  property p_hold_float;
    state_q == ebh_pkg::ST_HOLD |-> !RW_OE && !IO_STROBE_N_OE && !BUS_DRIVE_EN;
  endproperty
  a_hold_float: assert property (p_hold_float) // R5
    else $error("control driven during hold");

  property p_io_strobe;
    !IO_STROBE_N_O |-> !IO_SPACE_SEL_N_O && MEMORY_STROBE_N_O;
  endproperty
  a_io_strobe: assert property (p_io_strobe) // R6
    else $error("io strobe without io space");

  property p_hold_ack;
    !HOLD_ACK_N_O |-> state_q == ebh_pkg::ST_HOLD && !SPACE_SEL_N_OE;
  endproperty
  a_hold_ack: assert property (p_hold_ack) // R9
    else $error("hold ack low outside floated hold");

  property p_off_float;
    !sync.off_n |=> !WAIT_COMPLETE_N_OE && !FETCH_INDICATOR_N_OE && !HOLD_ACK_N_OE;
  endproperty
  a_off_float: assert property (p_off_float) // R13
    else $error("pin driven while float low");

  // Long access must open its first software wait with wait-complete low
  property p_wait_complete;
    s_long_access |=> s_first_wait;
  endproperty
  a_wait_complete: assert property (p_wait_complete) // R11
    else $error("wait complete not low at first wait");

  property p_div_toggle;
    div_cnt_q >= div_sel_q |=> $changed(DIVIDED_CLOCK_OUT_O);
  endproperty
  a_div_toggle: assert property (p_div_toggle) // R15
    else $error("clock output missed its toggle");

  property p_no_mid_hold;
    state_q == ebh_pkg::ST_SWWAIT || state_q == ebh_pkg::ST_XWAIT |=>
      state_q != ebh_pkg::ST_HOLD;
  endproperty
  a_no_mid_hold: assert property (p_no_mid_hold) // R19
    else $error("hold granted mid access");

endmodule

`default_nettype wire

// File: verilog/ebh_pkg.sv
// Shared constants and types for the external bus handshake block.
// Assumes one clock (MCLK) and an asynchronous active-low reset.
// Summary of operation
// R1: Ready low stretches the access one cycle, then ready is checked again.
// R2: Ready is only examined when two or more software wait states are set.
// R3: Ready is not sampled before all software wait states have elapsed.
// R4: Direction output rests high and goes low only during an external write.
// R5: Direction output floats during hold and while float input is low.
// R6: I/O strobe rests high and goes low only for an I/O device access.
// R7: I/O strobe floats during hold and while float input is low.
// R8: Master requests hold; once acknowledged, address, data, control lines float.
// R9: Hold acknowledge low only in hold with lines floated; floats when float low.
// R10: Hold acknowledge is driven high throughout reset.
// R11: Wait-complete goes low at first software wait, high at the last one.
// R12: Wait-complete looped to ready forces exactly one extra external wait; here none up to four software waits, four from five.
// R13: Wait-complete floats while the float input is low.
// R14: Fetch indicator low while an instruction address is out; floats on float.
// R15: Clock output is machine rate divided by one to four, software selected; each level here lasts one to four MCLK cycles.
// R16: After reset the clock output divides by four.
// R17: Memory strobe low only for data or program memory access; floats in hold.
// R18: Space selects high except the accessed space, active while address valid.
// R19: Hold is granted only between accesses, never in mid access.
`default_nettype none

package ebh_pkg;

  // Machine states of the bus sequencer
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACCESS,
    ST_SWWAIT,
    ST_XWAIT,
    ST_HOLD
  } ebh_state_e;

  // External space selected by an access
  typedef enum logic [1:0] {
    SPACE_DATA,
    SPACE_PROG,
    SPACE_IO
  } ebh_space_e;

  localparam int WS_WIDTH = 3;
  localparam logic [WS_WIDTH-1:0] READY_MIN_WS = 3'h2;
  localparam logic [1:0] DIV_SEL_RESET = 2'h3;
  localparam int SYNC_STAGES = 3;
  localparam logic [2:0] SYNC_RESET = 3'h7;
  localparam int SYNC_READY_BIT = 0;
  localparam int SYNC_HOLD_BIT = 1;
  localparam int SYNC_OFF_BIT = 2;

endpackage

`default_nettype wire

// File: verilog/ebh_sync_if.sv
// Carrier for the filtered pin levels between synchroniser and sequencer.
// Assumes both ends sit on MCLK.
`default_nettype none

interface ebh_sync_if;
  logic ready;
  logic hold_n;
  logic off_n;

  modport src (output ready, output hold_n, output off_n);
  modport dst (input ready, input hold_n, input off_n);
endinterface

`default_nettype wire

// File: verilog/ebh_pin_sync.sv
// Three-stage synchroniser with agreement filter for the asynchronous pins.
// Assumes pins change freely relative to MCLK.
`default_nettype none

module ebh_pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] pins,
  ebh_sync_if.src sync
);

  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] filt_q;
  logic [2:0] filt_d;

  ////////////////////////////////////////////////////////////////////////////
  // A change counts only once stages two and three agree; stage one is
  // read by stage two alone, so no glitch reaches the filter.
  assign filt_d = (s2_q & s3_q) | (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & filt_q);

  // Shift chain and filtered level
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= ebh_pkg::SYNC_RESET;
      s2_q <= ebh_pkg::SYNC_RESET;
      s3_q <= ebh_pkg::SYNC_RESET;
      filt_q <= ebh_pkg::SYNC_RESET;
    end
    else
    begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  // Named filtered levels
  assign sync.ready = filt_q[ebh_pkg::SYNC_READY_BIT];
  assign sync.hold_n = filt_q[ebh_pkg::SYNC_HOLD_BIT];
  assign sync.off_n = filt_q[ebh_pkg::SYNC_OFF_BIT];

endmodule

`default_nettype wire

// File: verification/ebh_far_model.sv
// Far-side model: external memories and I/O devices that answer with
// ready, and a bus master that asks for hold.
// Assumes the bench supplies MCLK, reset and the mode controls.
`default_nettype none

module ebh_far_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mem_strobe_n,
  input wire logic mem_strobe_oe,
  input wire logic io_strobe_n,
  input wire logic io_strobe_oe,
  input wire logic slow_en,
  input wire logic [3:0] slow_cycles,
  input wire logic hold_req,
  output logic ready,
  output logic hold_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic act;
  logic [3:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // A device counts as selected only when its strobe is driven and low
  assign act = (mem_strobe_oe && !mem_strobe_n) || (io_strobe_oe && !io_strobe_n);
  // Slow device is not ready while idle, so a late sampler sees low
  assign ready = !slow_en || (act && (cnt_q >= slow_cycles));
  // Hold master asks for the bus on command
  assign hold_n = !hold_req;

  // Strobe age; saturates so a long stall never wraps back to not ready
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 4'h0;
    else if (!act)
      cnt_q <= 4'h0;
    else if (cnt_q != 4'hf)
      cnt_q <= cnt_q + 4'h1;
  end
endmodule

`default_nettype wire

// File: verification/external_bus_handshake_test.sv
// Self-checking bench for the external bus sequencer.
// Assumes ebh_pkg, the sync interface and ebh_far_model are compiled first.
`default_nettype none

`define EBH_CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module external_bus_handshake_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [1:0] req_space = 2'h0;
  logic req_fetch = 1'b0;
  logic [2:0] wait_states = 3'h0;
  logic div_wr = 1'b0;
  logic [1:0] div_sel = 2'h0;
  logic off_n = 1'b1;
  logic slow_en = 1'b0;
  logic [3:0] slow_cycles = 4'h0;
  logic hold_req = 1'b0;
  logic ready;
  logic hold_n;
  logic bus_idle, acc_done, bus_drive_en, rw_o, rw_oe, io_o, io_oe, mem_o, mem_oe;
  logic data_sel_n, prog_sel_n, io_sel_n, sel_oe, hack_o, hack_oe;
  logic wc_o, wc_oe, fi_o, fi_oe, dclk_o, dclk_oe;
  int errors = 0;
  int checked = 0;

  ////////////////////////////////////////////////////////////////////////////
  // 25 MHz machine clock
  always #20 mclk = ~mclk;

  ebh_bus_ctrl #(.WS_W(3)) ebh_bus_ctrl_i (
    .MCLK(mclk), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
    .REQ_SPACE(req_space), .REQ_FETCH(req_fetch), .WAIT_STATES(wait_states),
    .DIV_WR(div_wr), .DIV_SEL(div_sel), .READY(ready), .HOLD_N(hold_n), .OFF_N(off_n),
    .BUS_IDLE(bus_idle), .ACC_DONE(acc_done), .BUS_DRIVE_EN(bus_drive_en),
    .RW_O(rw_o), .RW_OE(rw_oe), .IO_STROBE_N_O(io_o), .IO_STROBE_N_OE(io_oe),
    .MEMORY_STROBE_N_O(mem_o), .MEMORY_STROBE_N_OE(mem_oe),
    .DATA_SPACE_SEL_N_O(data_sel_n), .PROGRAM_SPACE_SEL_N_O(prog_sel_n),
    .IO_SPACE_SEL_N_O(io_sel_n), .SPACE_SEL_N_OE(sel_oe),
    .HOLD_ACK_N_O(hack_o), .HOLD_ACK_N_OE(hack_oe),
    .WAIT_COMPLETE_N_O(wc_o), .WAIT_COMPLETE_N_OE(wc_oe),
    .FETCH_INDICATOR_N_O(fi_o), .FETCH_INDICATOR_N_OE(fi_oe),
    .DIVIDED_CLOCK_OUT_O(dclk_o), .DIVIDED_CLOCK_OUT_OE(dclk_oe));

  ebh_far_model ebh_far_model_i (
    .clk(mclk), .rst_n(rst_n), .mem_strobe_n(mem_o), .mem_strobe_oe(mem_oe),
    .io_strobe_n(io_o), .io_strobe_oe(io_oe), .slow_en(slow_en),
    .slow_cycles(slow_cycles), .hold_req(hold_req), .ready(ready), .hold_n(hold_n));

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    begin
      if (errors == 0 && checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // Request is raised only once idle is seen, so it is never refused
  task automatic issue(input logic wr, input logic [1:0] sp, input logic fe,
                       input logic [2:0] ws);
    int k;
    begin
      @(negedge mclk);
      for (k = 0; k < 60 && bus_idle !== 1'b1; k++)
        @(negedge mclk);
      @(posedge mclk);
      req_valid <= 1'b1;
      req_write <= wr;
      req_space <= sp;
      req_fetch <= fe;
      wait_states <= ws;
      @(posedge mclk);
      req_valid <= 1'b0;
    end
  endtask

  // One access: pins checked every active cycle, length within lo..hi
  task automatic acc(input logic wr, input logic [1:0] sp, input logic fe,
                     input logic [2:0] ws, input int lo, input int hi);
    int n;
    int wl;
    begin
      issue(wr, sp, fe, ws);
      n = 0;
      wl = 0;
      @(negedge mclk);
      while (acc_done !== 1'b1 && n < 40)
      begin
        n++;
        if (wc_o === 1'b0)
          wl++;
        `EBH_CHK(rw_o, !wr)
        `EBH_CHK(io_o, sp != 2'h2)
        `EBH_CHK(mem_o, sp > 2'h1)
        `EBH_CHK({data_sel_n, prog_sel_n, io_sel_n}, {sp != 2'h0, sp != 2'h1, sp != 2'h2})
        `EBH_CHK(fi_o, !(fe && sp == 2'h1))
        @(negedge mclk);
      end
      `EBH_CHK(n >= lo && n <= hi, 1'b1)
      `EBH_CHK(wl, (ws >= 3'h2) ? int'(ws) - 1 : 0)
      `EBH_CHK({rw_o, io_o, mem_o, wc_o}, 4'hf)
    end
  endtask

  // Every space in both directions, prompt device
  task automatic t_spaces;
    int i;
    begin
      for (i = 0; i < 8; i++)
        acc(i[2], i[1:0], 1'b1, 3'h2, 3, 3);
    end
  endtask

  // Slow device: stretched only when ready is looked at, and only late
  task automatic t_ready;
    begin
      @(posedge mclk);
      slow_en <= 1'b1;
      slow_cycles <= 4'h6;
      acc(1'b0, 2'h0, 1'b0, 3'h2, 4, 16);
      acc(1'b1, 2'h2, 1'b0, 3'h1, 2, 2);
      acc(1'b0, 2'h1, 1'b1, 3'h0, 1, 1);
      @(posedge mclk);
      slow_cycles <= 4'h0;
      acc(1'b0, 2'h0, 1'b0, 3'h7, 8, 8);
      @(posedge mclk);
      slow_en <= 1'b0;
    end
  endtask

  // Hold asked for in mid access: granted only after the access ends
  task automatic t_hold;
    logic seen;
    int k;
    begin
      issue(1'b0, 2'h0, 1'b0, 3'h7);
      @(posedge mclk);
      hold_req <= 1'b1;
      seen = 1'b0;
      for (k = 0; k < 60 && hack_o !== 1'b0; k++)
      begin
        @(negedge mclk);
        if (acc_done === 1'b1)
          seen = 1'b1;
      end
      `EBH_CHK(seen, 1'b1)
      `EBH_CHK({hack_o, hack_oe}, 2'h1)
      `EBH_CHK(rw_oe, 1'b0)
      `EBH_CHK(io_oe, 1'b0)
      `EBH_CHK({mem_oe, sel_oe, bus_drive_en}, 3'h0)
      `EBH_CHK(bus_idle, 1'b0)
      @(posedge mclk);
      hold_req <= 1'b0;
      for (k = 0; k < 20 && hack_o !== 1'b1; k++)
        @(negedge mclk);
      @(negedge mclk);
      `EBH_CHK({hack_o, rw_oe}, 2'h3)
    end
  endtask

  // Global float: direction, I/O strobe, hold ack, wait-complete, fetch and clock outputs let go; all but I/O strobe and hold ack are checked to return
  task automatic t_off;
    begin
      @(posedge mclk);
      off_n <= 1'b0;
      repeat (8) @(negedge mclk);
      `EBH_CHK({rw_oe, io_oe}, 2'h0)
      `EBH_CHK(hack_oe, 1'b0)
      `EBH_CHK(wc_oe, 1'b0)
      `EBH_CHK(fi_oe, 1'b0)
      `EBH_CHK(dclk_oe, 1'b0)
      @(posedge mclk);
      off_n <= 1'b1;
      repeat (8) @(negedge mclk);
      `EBH_CHK({wc_oe, fi_oe, rw_oe}, 3'h7)
      `EBH_CHK(dclk_oe, 1'b1)
    end
  endtask

  // Length of the level starting at the current sample point
  task automatic level_len(output int n);
    logic p;
    begin
      p = dclk_o;
      n = 0;
      do
      begin
        @(negedge mclk);
        n++;
      end
      while (dclk_o === p && n < 20);
    end
  endtask

  // Divider: first two levels after a change may be partial, so skipped
  task automatic t_div(input logic [1:0] sel, input logic load);
    int n;
    int k;
    begin
      if (load)
      begin
        @(posedge mclk);
        div_wr <= 1'b1;
        div_sel <= sel;
        @(posedge mclk);
        div_wr <= 1'b0;
      end
      @(negedge mclk);
      level_len(n);
      level_len(n);
      for (k = 0; k < 2; k++)
      begin
        level_len(n);
        `EBH_CHK(n, int'(sel) + 1)
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well past the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    int i;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    `EBH_CHK({hack_o, hack_oe}, 2'h3)
    `EBH_CHK({rw_o, io_o, mem_o}, 3'h7)
    @(posedge mclk);
    rst_n <= 1'b1;
    t_div(2'h3, 1'b0);
    t_spaces();
    t_ready();
    t_hold();
    t_off();
    for (i = 0; i < 4; i++)
      t_div(2'(i), 1'b1);
    end_sim();
  end
endmodule

`default_nettype wire
